// *** hdl/rsu_pkg.sv ***
// Constants, types and register map of the remote upgrade control block.
package rsu_pkg;

	////////////////////////////////////////////////////////////////////////////
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	localparam logic [ADDR_W-1:0] ADDR_CTRL_LO  = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_CTRL_HI  = 8'h04;
	localparam logic [ADDR_W-1:0] ADDR_STATUS   = 8'h08;
	localparam logic [ADDR_W-1:0] ADDR_COMMAND  = 8'h0C;
	localparam logic [ADDR_W-1:0] ADDR_WD_COUNT = 8'h10;
	localparam logic [ADDR_W-1:0] ADDR_BOOT     = 8'h14;

	////////////////////////////////////////////////////////////////////////////
	localparam int CTRL_W      = 39;
	localparam int CTRL_HI_LSB = 32;
	localparam int CTRL_HI_W   = CTRL_W - CTRL_HI_LSB;

	localparam int CMD_KICK_BIT    = 0;
	localparam int CMD_LAUNCH_BIT  = 1;
	localparam int CMD_FACTORY_BIT = 2;

	localparam int ST_W         = 5;
	localparam int ST_CRC       = 0;
	localparam int ST_PIN       = 1;
	localparam int ST_ARRAY     = 2;
	localparam int ST_WDOG      = 3;
	localparam int ST_EARLY     = 4;
	localparam int ST_APP_MODE  = 8;
	localparam int ST_OSC_BIT   = 9;
	localparam int ST_EARLY_BIT = 10;

	localparam int WD_COUNT_W  = 29;
	localparam int BOOT_ADDR_W = 24;
	localparam logic [16:0] WD_LOW_PATTERN = 17'h00008;
	localparam logic [1:0]  BOOT_LOW_BITS  = 2'h0;
	localparam logic        RSV_LOW_VALUE  = 1'h0;
	localparam logic        RSV_HIGH_VALUE = 1'h1;

	////////////////////////////////////////////////////////////////////////////
	// Field order, most significant first, matches bits 38 down to 0.
	typedef struct packed {
		logic        reserved_high_bit;
		logic        early_done_check_bit;
		logic        osc_int_bit;
		logic        watchdog_enable_bit;
		logic        reserved_low_bit;
		logic [21:0] boot_address_field;
		logic [11:0] watchdog_timeout_field;
	} rsu_ctrl_s;

	localparam rsu_ctrl_s CTRL_RESET = '{
		reserved_high_bit:      1'h1,
		early_done_check_bit:   1'h1,
		osc_int_bit:            1'h1,
		watchdog_enable_bit:    1'h1,
		reserved_low_bit:       1'h0,
		boot_address_field:     22'h000000,
		watchdog_timeout_field: 12'h000
	};

	typedef enum logic [1:0] {
		RSU_FACTORY,
		RSU_LOADING,
		RSU_APP
	} rsu_state_e;

endpackage

// *** hdl/rsu_upgrade_ctrl.sv ***
// Remote upgrade control: control and status registers, watchdog and reload sequencing.
`timescale 1ns/1ps

module rsu_upgrade_ctrl
	import rsu_pkg::*;
(
	// Clock and reset
	input  wire logic                   CLK_SYS,
	input  wire logic                   RST,
	// Register port
	input  wire logic [ADDR_W-1:0]      REG_ADDR,
	input  wire logic [DATA_W-1:0]      REG_WDATA,
	input  wire logic                   REG_WR,
	input  wire logic                   REG_RD,
	output logic      [DATA_W-1:0]      REG_RDATA,
	// Configuration pins
	input  wire logic                   CONFIG_COMPLETE_PIN,
	input  wire logic                   CONFIG_STATUS_PIN_N,
	// Loader status
	input  wire logic                   LOAD_DONE,
	input  wire logic                   IMAGE_VALID,
	input  wire logic                   IMAGE_SIZE_OK,
	input  wire logic                   CRC_ERROR,
	// Reconfiguration outputs
	output logic                        RECONFIG_REQ,
	output logic                        RECONFIG_APP,
	output logic      [BOOT_ADDR_W-1:0] BOOT_ADDR,
	output logic                        OSC_INT_SEL,
	output logic                        EARLY_CHECK_EN,
	output logic                        WATCHDOG_EXPIRED
);

	////////////////////////////////////////////////////////////////////////////
	function automatic logic [WD_COUNT_W-1:0] wd_reload(input rsu_ctrl_s c);
		wd_reload = {c.watchdog_timeout_field, WD_LOW_PATTERN};
	endfunction

	function automatic logic [BOOT_ADDR_W-1:0] boot_of(input rsu_ctrl_s c);
		boot_of = {c.boot_address_field, BOOT_LOW_BITS};
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers: bit 0 is completion, bit 1 is the status pin.
	logic [1:0] sync1_reg, sync2_reg, sync3_reg, filt_reg;
	logic [1:0] sync1_next, sync2_next, sync3_next, filt_next;

	always_comb begin
		sync1_next = {CONFIG_STATUS_PIN_N, CONFIG_COMPLETE_PIN};
		sync2_next = sync1_reg;
		sync3_next = sync2_reg;
		// A change counts only once the last two stages agree.
		filt_next = (sync2_reg & sync3_reg) | (filt_reg & (sync2_reg ^ sync3_reg));
	end

	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			sync1_reg <= 2'h2;
			sync2_reg <= 2'h2;
			sync3_reg <= 2'h2;
			filt_reg  <= 2'h2;
		end else begin
			sync1_reg <= sync1_next;
			sync2_reg <= sync2_next;
			sync3_reg <= sync3_next;
			filt_reg  <= filt_next;
		end
	end

	logic cfg_done;
	logic status_low;
	assign cfg_done   = filt_reg[0];
	assign status_low = ~filt_reg[1];

	////////////////////////////////////////////////////////////////////////////
	logic kick, launch, array_trig;
	assign kick       = REG_WR && (REG_ADDR == ADDR_COMMAND) && REG_WDATA[CMD_KICK_BIT];
	assign launch     = REG_WR && (REG_ADDR == ADDR_COMMAND) && REG_WDATA[CMD_LAUNCH_BIT];
	assign array_trig = REG_WR && (REG_ADDR == ADDR_COMMAND) && REG_WDATA[CMD_FACTORY_BIT];

	rsu_ctrl_s ctrl_reg, ctrl_next;

	always_comb begin
		ctrl_next = ctrl_reg;
		if (REG_WR && (REG_ADDR == ADDR_CTRL_LO)) begin
			ctrl_next[CTRL_HI_LSB-1:0] = REG_WDATA;
		end
		if (REG_WR && (REG_ADDR == ADDR_CTRL_HI)) begin
			ctrl_next[CTRL_W-1:CTRL_HI_LSB] = REG_WDATA[CTRL_HI_W-1:0];
		end
		// Reserved bits are pinned so stray writes cannot make them carry meaning.
		ctrl_next.reserved_low_bit  = RSV_LOW_VALUE;
		ctrl_next.reserved_high_bit = RSV_HIGH_VALUE;
	end

	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			ctrl_reg <= CTRL_RESET;
		end else begin
			ctrl_reg <= ctrl_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Reconfiguration sequencer.
	rsu_state_e               state_reg, state_next;
	logic                     req_reg, req_next;
	logic                     app_reg, app_next;
	logic                     osc_reg, osc_next;
	logic                     early_reg, early_next;
	logic [BOOT_ADDR_W-1:0]   boot_reg, boot_next;
	logic [ST_W-1:0]          cause_set;
	logic                     fallback, app_enter, wd_fire;

	always_comb begin
		state_next = state_reg;
		req_next   = 1'b0;
		app_next   = app_reg;
		osc_next   = osc_reg;
		early_next = early_reg;
		boot_next  = boot_reg;
		cause_set  = '0;
		fallback   = 1'b0;
		app_enter  = 1'b0;
		unique case (state_reg)
			RSU_FACTORY: begin
				if (launch) begin
					state_next = RSU_LOADING;
					req_next   = 1'b1;
					app_next   = 1'b1;
					boot_next  = boot_of(ctrl_reg);
					osc_next   = ctrl_reg.osc_int_bit;
					early_next = ctrl_reg.early_done_check_bit;
				end
			end
			RSU_LOADING: begin
				if (CRC_ERROR) begin
					cause_set[ST_CRC] = 1'b1;
					fallback          = 1'b1;
				end else if (early_reg && cfg_done && !LOAD_DONE) begin
					cause_set[ST_EARLY] = 1'b1;
					fallback            = 1'b1;
				end else if (LOAD_DONE) begin
					if (early_reg && !(IMAGE_VALID && IMAGE_SIZE_OK)) begin
						cause_set[ST_EARLY] = 1'b1;
						fallback            = 1'b1;
					end else begin
						state_next = RSU_APP;
						app_enter  = 1'b1;
					end
				end
			end
			RSU_APP: begin
				if (wd_fire) begin
					cause_set[ST_WDOG] = 1'b1;
					fallback           = 1'b1;
				end
			end
		endcase
		if (status_low && (state_reg != RSU_FACTORY)) begin
			cause_set[ST_PIN] = 1'b1;
			fallback          = 1'b1;
		end
		if (array_trig) begin
			cause_set[ST_ARRAY] = 1'b1;
			fallback            = 1'b1;
		end
		if (fallback) begin
			state_next = RSU_FACTORY;
			req_next   = 1'b1;
			app_next   = 1'b0;
			osc_next   = 1'b0;
			early_next = 1'b0;
			app_enter  = 1'b0;
		end
	end

	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			state_reg <= RSU_FACTORY;
			req_reg   <= 1'b0;
			app_reg   <= 1'b0;
			osc_reg   <= 1'b0;
			early_reg <= 1'b0;
			boot_reg  <= '0;
		end else begin
			state_reg <= state_next;
			req_reg   <= req_next;
			app_reg   <= app_next;
			osc_reg   <= osc_next;
			early_reg <= early_next;
			boot_reg  <= boot_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Watchdog, running only in application mode.
	logic [WD_COUNT_W-1:0] wd_reg, wd_next;
	logic                  wdx_reg, wdx_next;

	assign wd_fire = (state_reg == RSU_APP) && ctrl_reg.watchdog_enable_bit
		&& (wd_reg == '0) && !kick;

	always_comb begin
		wd_next  = wd_reg;
		wdx_next = wd_fire;
		if (kick || app_enter) begin
			wd_next = wd_reload(ctrl_reg);
		end else if ((state_reg == RSU_APP) && ctrl_reg.watchdog_enable_bit
			&& (wd_reg != '0)) begin
			wd_next = wd_reg - 1'b1;
		end
	end

	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			wd_reg  <= '0;
			wdx_reg <= 1'b0;
		end else begin
			wd_reg  <= wd_next;
			wdx_reg <= wdx_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Status and read path.
	logic [ST_W-1:0]   status_reg, status_next;
	logic [DATA_W-1:0] rdata_reg, rdata_next;

	always_comb begin
		status_next = status_reg;
		if (REG_WR && (REG_ADDR == ADDR_STATUS)) begin
			status_next = status_reg & ~REG_WDATA[ST_W-1:0];
		end
		// cause recording; a new cause wins over a same-cycle clear.
		status_next = status_next | cause_set;
		rdata_next = '0;
		if (REG_RD) begin
			case (REG_ADDR)
				ADDR_CTRL_LO:  rdata_next = ctrl_reg[CTRL_HI_LSB-1:0];
				ADDR_CTRL_HI:  rdata_next[CTRL_HI_W-1:0] = ctrl_reg[CTRL_W-1:CTRL_HI_LSB];
				ADDR_STATUS: begin
					rdata_next[ST_W-1:0]    = status_reg;
					rdata_next[ST_APP_MODE] = app_reg;
					rdata_next[ST_OSC_BIT]  = osc_reg;
					rdata_next[ST_EARLY_BIT] = early_reg;
				end
				ADDR_WD_COUNT: rdata_next[WD_COUNT_W-1:0] = wd_reg;
				ADDR_BOOT:     rdata_next[BOOT_ADDR_W-1:0] = boot_reg;
				default:       rdata_next = '0;
			endcase
		end
	end

	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			status_reg <= '0;
			rdata_reg  <= '0;
		end else begin
			status_reg <= status_next;
			rdata_reg  <= rdata_next;
		end
	end

	assign REG_RDATA        = rdata_reg;
	assign RECONFIG_REQ     = req_reg;
	assign RECONFIG_APP     = app_reg;
	assign BOOT_ADDR        = boot_reg;
	assign OSC_INT_SEL      = osc_reg;
	assign EARLY_CHECK_EN   = early_reg;
	assign WATCHDOG_EXPIRED = wdx_reg;

	////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (RST);

	ctrl_layout_a: assert property (
		REG_WR && (REG_ADDR == ADDR_CTRL_HI)
		|=> ctrl_reg.watchdog_enable_bit == $past(REG_WDATA[3])
		&& ctrl_reg.reserved_high_bit && !ctrl_reg.reserved_low_bit)
		else $error("control high word not laid out as expected");
	wd_reload_a: assert property (
		kick |=> wd_reg == {$past(ctrl_reg.watchdog_timeout_field), WD_LOW_PATTERN})
		else $error("watchdog reload value wrong");
	boot_addr_a: assert property (
		(state_reg == RSU_FACTORY) && launch && !array_trig
		|=> BOOT_ADDR == {$past(ctrl_reg.boot_address_field), 2'b00} && RECONFIG_REQ)
		else $error("boot address not formed from field");
	wd_hold_a: assert property (
		!ctrl_reg.watchdog_enable_bit && !kick && !app_enter |=> $stable(wd_reg))
		else $error("watchdog moved while disabled");
	osc_sel_a: assert property (
		(state_reg == RSU_FACTORY) && launch && !array_trig
		|=> OSC_INT_SEL == $past(ctrl_reg.osc_int_bit) ##1 (OSC_INT_SEL || !RECONFIG_APP))
		else $error("startup oscillator select not taken at launch");
	image_check_a: assert property (
		(state_reg == RSU_LOADING) && early_reg && !CRC_ERROR && !cfg_done && LOAD_DONE
		&& !(IMAGE_VALID && IMAGE_SIZE_OK)
		|=> RECONFIG_REQ && !RECONFIG_APP && (state_reg == RSU_FACTORY) && status_reg[ST_EARLY])
		else $error("bad image did not reload factory");
	early_done_a: assert property (
		(state_reg == RSU_LOADING) && early_reg && cfg_done && !LOAD_DONE
		|=> RECONFIG_REQ && !RECONFIG_APP)
		else $error("premature completion not caught");
	crc_cause_a: assert property (
		(state_reg == RSU_LOADING) && CRC_ERROR |=> status_reg[ST_CRC] ##1 (status_reg[ST_CRC]
		|| $past(REG_WR && (REG_ADDR == ADDR_STATUS) && REG_WDATA[ST_CRC])))
		else $error("CRC cause not recorded");
	pin_cause_a: assert property (
		status_low && (state_reg != RSU_FACTORY) |=> status_reg[ST_PIN] && !RECONFIG_APP)
		else $error("status pin cause not recorded");

endmodule

// *** tb/rsu_loader_model.sv ***
// Behavioural loader that answers the block's reconfiguration requests.
`timescale 1ns/1ps

module rsu_loader_model (
	// Clock and reset
	input  wire logic       CLK_SYS,
	input  wire logic       RST,
	// Requests and commanded behaviour
	input  wire logic       RECONFIG_REQ,
	input  wire logic       RECONFIG_APP,
	input  wire logic [1:0] MODE,
	input  wire logic [4:0] DELAY,
	// Loader status
	output logic            LOAD_DONE,
	output logic            IMAGE_VALID,
	output logic            IMAGE_SIZE_OK,
	output logic            CRC_ERROR,
	output logic            CONFIG_COMPLETE_PIN
);
	logic [4:0] cnt_reg;
	logic       busy_reg;

	////////////////////////////////////////////////////////////////////////////
	// Mode 0 loads a good image, 1 a bad one, 2 meets a CRC error, 3 completes early.
	// Valid and size toggle while unsampled, so a stale level never passes for a verdict.
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			{cnt_reg, busy_reg, LOAD_DONE, CRC_ERROR, CONFIG_COMPLETE_PIN} <= '0;
			IMAGE_VALID   <= 1'h0;
			IMAGE_SIZE_OK <= 1'h1;
		end else begin
			LOAD_DONE     <= 1'h0;
			CRC_ERROR     <= 1'h0;
			IMAGE_VALID   <= ~IMAGE_VALID;
			IMAGE_SIZE_OK <= ~IMAGE_SIZE_OK;
			if (RECONFIG_REQ) begin
				busy_reg            <= RECONFIG_APP;
				cnt_reg             <= DELAY;
				CONFIG_COMPLETE_PIN <= RECONFIG_APP && (MODE == 2'h3);
			end else if (busy_reg && cnt_reg != 5'h00) begin
				cnt_reg <= cnt_reg - 5'h01;
			end else if (busy_reg) begin
				busy_reg            <= 1'h0;
				CRC_ERROR           <= (MODE == 2'h2);
				LOAD_DONE           <= (MODE != 2'h2);
				IMAGE_VALID         <= (MODE != 2'h1);
				IMAGE_SIZE_OK       <= (MODE != 2'h1);
				CONFIG_COMPLETE_PIN <= (MODE == 2'h0) || (MODE == 2'h3);
			end
		end
	end
endmodule

// *** tb/tb_remote_upgrade_control.sv ***
// Self-checking testbench of the remote upgrade control block.
`timescale 1ns/1ps

module tb_remote_upgrade_control
	import rsu_pkg::*;
;
	logic                   clk_sys;
	logic                   rst;
	logic [ADDR_W-1:0]      reg_addr;
	logic [DATA_W-1:0]      reg_wdata;
	logic                   reg_wr;
	logic                   reg_rd;
	logic [DATA_W-1:0]      reg_rdata;
	logic                   complete_pin;
	logic                   status_pin_n;
	logic                   load_done;
	logic                   image_valid;
	logic                   image_size_ok;
	logic                   crc_error;
	logic                   req;
	logic                   app;
	logic [BOOT_ADDR_W-1:0] boot_addr;
	logic                   osc_sel;
	logic                   early_en;
	logic                   wd_expired;
	logic [1:0]             mode;
	logic [4:0]             delay;
	logic [DATA_W-1:0]      d;
	logic [1:0]             m_tab [3] = '{2'h2, 2'h1, 2'h3};
	logic [DATA_W-1:0]      s_tab [3] = '{32'h01, 32'h10, 32'h10};
	int                     err_count = 0;
	int                     n_checks = 0;
	int                     req_cnt = 0;
	int                     exp_cnt = 0;
	int                     cyc = 0;

	rsu_upgrade_ctrl i_dut (.CLK_SYS(clk_sys), .RST(rst), .REG_ADDR(reg_addr),
		.REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
		.CONFIG_COMPLETE_PIN(complete_pin), .CONFIG_STATUS_PIN_N(status_pin_n),
		.LOAD_DONE(load_done), .IMAGE_VALID(image_valid), .IMAGE_SIZE_OK(image_size_ok),
		.CRC_ERROR(crc_error), .RECONFIG_REQ(req), .RECONFIG_APP(app), .BOOT_ADDR(boot_addr),
		.OSC_INT_SEL(osc_sel), .EARLY_CHECK_EN(early_en), .WATCHDOG_EXPIRED(wd_expired));

	rsu_loader_model i_loader (.CLK_SYS(clk_sys), .RST(rst), .RECONFIG_REQ(req),
		.RECONFIG_APP(app), .MODE(mode), .DELAY(delay), .LOAD_DONE(load_done),
		.IMAGE_VALID(image_valid), .IMAGE_SIZE_OK(image_size_ok), .CRC_ERROR(crc_error),
		.CONFIG_COMPLETE_PIN(complete_pin));

	initial begin
		clk_sys = 1'h0;
		forever #5 clk_sys = ~clk_sys;
	end

	////////////////////////////////////////////////////////////////////////////
	task automatic complete_run();
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// Pulses are counted at the edge, so a one-cycle output is never missed.
	always @(posedge clk_sys) begin
		cyc++;
		if (req === 1'h1) req_cnt++;
		if (wd_expired === 1'h1) exp_cnt++;
		if (cyc == 5000) begin
			err_count++;
			complete_run();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk_sys);
		reg_wr    <= 1'h1;
		reg_addr  <= a;
		reg_wdata <= v;
		@(posedge clk_sys);
		reg_wr <= 1'h0;
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge clk_sys);
		reg_rd   <= 1'h1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'h0;
		#1;
		d = reg_rdata;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		rd(a);
		check(d & m, e);
	endtask

	task automatic launch(input logic [1:0] m, input logic [4:0] t);
		mode  <= m;
		delay <= t;
		wr(ADDR_COMMAND, 32'h2);
	endtask

	////////////////////////////////////////////////////////////////////////////
	initial begin
		{rst, reg_wr, reg_rd, status_pin_n} = 4'h9;
		reg_addr  = 8'h00;
		reg_wdata = 32'h0;
		mode      = 2'h0;
		delay     = 5'h03;
		repeat (4) @(posedge clk_sys);
		rst <= 1'h0;
		rd_chk(ADDR_CTRL_LO, 32'hFFFFFFFF, 32'h0);
		rd_chk(ADDR_CTRL_HI, 32'hFFFFFFFF, 32'h78);
		rd_chk(8'hFC, 32'hFFFFFFFF, 32'h0);
		wr(ADDR_CTRL_LO, 32'hABCDE005);
		wr(ADDR_CTRL_HI, 32'h7F);
		rd_chk(ADDR_CTRL_HI, 32'hFFFFFFFF, 32'h7B);
		rd_chk(ADDR_CTRL_LO, 32'hFFFFFFFF, 32'hABCDE005);
		wr(ADDR_CTRL_HI, 32'h7B);
		launch(2'h0, 5'h03);
		repeat (2) @(posedge clk_sys);
		#1;
		check(boot_addr, {2'h3, 20'hABCDE, 2'h0});
		check(osc_sel, 1'h1);
		check(early_en, 1'h1);
		repeat (20) @(posedge clk_sys);
		rd_chk(ADDR_STATUS, 32'h100, 32'h100);
		// Kick first: the read samples the count one decrement after the reload.
		wr(ADDR_COMMAND, 32'h1);
		rd(ADDR_WD_COUNT);
		check(d, {3'h0, 12'h005, WD_LOW_PATTERN} - 32'h1);
		// Clearing the enable must freeze the count.
		wr(ADDR_CTRL_HI, 32'h73);
		rd(ADDR_WD_COUNT);
		rd_chk(ADDR_WD_COUNT, 32'hFFFFFFFF, d);
		wr(ADDR_CTRL_HI, 32'h7B);
		wr(ADDR_COMMAND, 32'h2);
		repeat (4) @(posedge clk_sys);
		check(req_cnt, 1);
		wr(ADDR_COMMAND, 32'h4);
		repeat (4) @(posedge clk_sys);
		check(app, 1'h0);
		rd_chk(ADDR_STATUS, 32'h1F, 32'h04);
		wr(ADDR_STATUS, 32'h1F);
		for (int i = 0; i < 3; i++) begin
			launch(m_tab[i], 5'h10);
			repeat (40) @(posedge clk_sys);
			rd_chk(ADDR_STATUS, 32'h1F, s_tab[i]);
			wr(ADDR_STATUS, 32'h1F);
		end
		launch(2'h0, 5'h03);
		repeat (20) @(posedge clk_sys);
		status_pin_n <= 1'h0;
		repeat (8) @(posedge clk_sys);
		status_pin_n <= 1'h1;
		repeat (8) @(posedge clk_sys);
		rd_chk(ADDR_STATUS, 32'h1F, 32'h02);
		wr(ADDR_STATUS, 32'h1F);
		// A zero time-out gives the shortest watchdog run.
		wr(ADDR_CTRL_LO, 32'hABCDE000);
		launch(2'h0, 5'h03);
		repeat (40) @(posedge clk_sys);
		check(exp_cnt, 1);
		check(osc_sel, 1'h0);
		rd_chk(ADDR_STATUS, 32'h1F, 32'h08);
		check(req_cnt, 12);
		complete_run();
	end
endmodule
